// ---- verilog/pwc_regs.svh ----
// register offsets, field positions, reset values and write mask of the power control block
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH
`define PWC_CTL_OFFSET 4'h0
`define PWC_CTL_RESET 32'h00004000
`define PWC_CTL_WMASK 32'h0000C1F3
`define PWC_VS_HI 15
`define PWC_VS_LO 14
`define PWC_BKP_BIT 8
`define PWC_THR_HI 7
`define PWC_THR_LO 5
`define PWC_DET_EN_BIT 4
`define PWC_STB_CLR_BIT 3
`define PWC_WU_CLR_BIT 2
`define PWC_STB_SEL_BIT 1
`define PWC_LP_BIT 0
`endif

// ---- verilog/pwc_pkg.sv ----
// types shared by the power control block
package pwc_pkg;
	typedef enum logic [1:0] {
		PWC_RUN = 2'b00,
		PWC_DEEP = 2'b01,
		PWC_STANDBY = 2'b10
	} pwc_mode_e;
	typedef logic [31:0] pwc_word_t;
endpackage

// ---- verilog/pwc_flag.sv ----
// one sticky status flag with a set input and a clear strobe
`timescale 1ns/1ps
module pwc_flag
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic set_in,
	input wire logic clear_in,
	output logic flag_out
);
	logic next_flag;

	// set wins over a clear in the same cycle so no event is lost
	always_comb
	begin
		next_flag = flag_out;
		if (clear_in)
			next_flag = 1'b0;
		if (set_in)
			next_flag = 1'b1;
	end

	// only power-on reset clears the flag besides the strobe
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			flag_out <= 1'b0;
		else
			flag_out <= next_flag;
	end
endmodule // pwc_flag

// ---- verilog/pwc_ctrl.sv ----
// power control register with mode selection, detector lock and flag clear strobes
`timescale 1ns/1ps
`include "pwc_regs.svh"
module pwc_ctrl
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic por_rst_in,
	input wire logic standby_wakeup_in,
	input wire logic sel_in,
	input wire logic write_in,
	input wire logic [3:0] addr_in,
	input wire logic [1:0] size_in,
	input wire logic [3:0] byte_en_in,
	input wire pwc_pkg::pwc_word_t wdata_in,
	output pwc_pkg::pwc_word_t rdata_out,
	output logic error_out,
	input wire logic detector_lock_in,
	input wire logic core_deep_sleep_request_in,
	input wire logic internal_osc_8mhz_in,
	input wire logic wakeup_event_in,
	input wire logic backup_write_in,
	output logic backup_write_out,
	output logic regulator_voltage_low_out,
	output logic [2:0] detector_threshold_out,
	output logic detector_enable_out,
	output logic standby_flag_clear_out,
	output logic wakeup_flag_clear_out,
	output pwc_pkg::pwc_mode_e mode_out,
	output logic regulator_low_power_out,
	output logic standby_flag_out,
	output logic wakeup_flag_out
);
	import pwc_pkg::*;

	pwc_word_t ctl;
	pwc_word_t next_ctl;
	pwc_word_t next_rdata;
	logic next_error;
	logic access_ok;
	logic wr;
	pwc_word_t lane_mask;
	pwc_word_t wmask;
	pwc_mode_e next_mode;

	// only half-word (01) and word (10) sizes with a matching lane set are legal
	always_comb
	begin
		access_ok = 1'b0;
		if (size_in == 2'h2 && byte_en_in == 4'hF)
			access_ok = 1'b1;
		if (size_in == 2'h1 && (byte_en_in == 4'h3 || byte_en_in == 4'hC))
			access_ok = 1'b1;
		access_ok = access_ok && (addr_in == `PWC_CTL_OFFSET);
		wr = sel_in && write_in && access_ok;
	end

	// byte lanes mask the write; lock protects detector fields
	always_comb
	begin
		lane_mask = {{8{byte_en_in[3]}}, {8{byte_en_in[2]}}, {8{byte_en_in[1]}}, {8{byte_en_in[0]}}};
		wmask = `PWC_CTL_WMASK & lane_mask;
		if (detector_lock_in)
			wmask[`PWC_THR_HI:`PWC_DET_EN_BIT] = 4'h0;
		// clear bits are never stored, so they stay out of the write mask
		next_ctl = ctl;
		if (wr)
			next_ctl = (ctl & ~wmask) | (wdata_in & wmask);
	end

	// standby wakeup reloads the reset value as well as system reset
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			ctl <= `PWC_CTL_RESET;
		else if (standby_wakeup_in)
			ctl <= `PWC_CTL_RESET;
		else
			ctl <= next_ctl;
	end

	// read data is registered; strobe bits read as zero since they are not stored
	always_comb
	begin
		next_rdata = rdata_out;
		next_error = 1'b0;
		if (sel_in && !write_in && access_ok)
			next_rdata = ctl & lane_mask;
		if (sel_in && !access_ok)
			next_error = 1'b1;
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rdata_out <= 32'h00000000;
			error_out <= 1'b0;
		end
		else
		begin
			rdata_out <= next_rdata;
			error_out <= next_error;
		end
	end

	// clear strobes pulse on the write cycle itself
	assign standby_flag_clear_out = wr && byte_en_in[0] && wdata_in[`PWC_STB_CLR_BIT];
	assign wakeup_flag_clear_out = wr && byte_en_in[0] && wdata_in[`PWC_WU_CLR_BIT];

	// field decodes; code 00 is treated as high output
	assign regulator_voltage_low_out = ctl[`PWC_VS_HI];
	assign backup_write_out = backup_write_in && ctl[`PWC_BKP_BIT];
	assign detector_threshold_out = ctl[`PWC_THR_HI:`PWC_THR_LO];
	assign detector_enable_out = ctl[`PWC_DET_EN_BIT];

	// mode follows the core request; voltage select changes are left to software
	always_comb
	begin
		next_mode = PWC_RUN;
		if (core_deep_sleep_request_in)
			next_mode = ctl[`PWC_STB_SEL_BIT] ? PWC_STANDBY : PWC_DEEP;
		if (mode_out == PWC_STANDBY && core_deep_sleep_request_in)
			next_mode = PWC_STANDBY;
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			mode_out <= PWC_RUN;
		else
			mode_out <= next_mode;
	end

	// oscillator users override low power since they need a stable supply
	assign regulator_low_power_out = (mode_out == PWC_DEEP) && ctl[`PWC_LP_BIT] && !internal_osc_8mhz_in;

	// flags sit on power reset only, so they survive standby
	pwc_flag u_standby_flag
	(
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(por_rst_in),
		.set_in(mode_out == PWC_STANDBY),
		.clear_in(standby_flag_clear_out),
		.flag_out(standby_flag_out)
	);

	pwc_flag u_wakeup_flag
	(
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(por_rst_in),
		.set_in(wakeup_event_in),
		.clear_in(wakeup_flag_clear_out),
		.flag_out(wakeup_flag_out)
	);
endmodule // pwc_ctrl

// ---- tb/pwc_ctrl_properties.sv ----
// checker of the power control register ports
`timescale 1ns/1ps
module pwc_ctrl_properties
	import pwc_pkg::*;
(
	input logic sys_clk_in,
	input logic sys_rst_in,
	input logic sel_in,
	input logic write_in,
	input pwc_word_t wdata_in,
	input pwc_word_t rdata_out,
	input logic standby_flag_clear_out,
	input logic wakeup_flag_clear_out,
	input logic core_deep_sleep_request_in,
	input pwc_mode_e mode_out,
	input logic internal_osc_8mhz_in,
	input logic regulator_low_power_out,
	input logic standby_flag_out,
	input logic detector_lock_in,
	input logic standby_wakeup_in,
	input logic [2:0] detector_threshold_out,
	input logic detector_enable_out
);
	// one domain; system reset silences every check
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	read_zero_a: assert property ((rdata_out & 32'hFFFF3E0C) == 32'h0) else $error("rd");
	stb_pulse_a: assert property (standby_flag_clear_out |-> sel_in && write_in && wdata_in[3]) else $error("sc");
	wu_pulse_a: assert property (wakeup_flag_clear_out |-> sel_in && write_in && wdata_in[2]) else $error("wc");
	sleep_mode_a: assert property (core_deep_sleep_request_in |=> mode_out != PWC_RUN) else $error("md");
	mode_cause_a: assert property (mode_out != PWC_RUN |-> $past(core_deep_sleep_request_in)) else $error("mc");
	lp_gate_a: assert property (regulator_low_power_out |->
		mode_out == PWC_DEEP && !internal_osc_8mhz_in) else $error("lp");
	stb_set_a: assert property ($rose(standby_flag_out) |-> $past(mode_out) == PWC_STANDBY) else $error("sf");
	lock_hold_a: assert property (detector_lock_in && !standby_wakeup_in |=>
		$stable({detector_threshold_out, detector_enable_out})) else $error("lk");
	cover property (mode_out == PWC_STANDBY);
	cover property (regulator_low_power_out);
	cover property (standby_flag_clear_out);
endmodule // pwc_ctrl_properties
bind pwc_ctrl pwc_ctrl_properties chk (.*);

// ---- tb/tb_pwc_ctrl.sv ----
// bench for the power control register
`timescale 1ns/1ps
module tb_pwc_ctrl;
	import pwc_pkg::*;
	logic sys_clk_in = 0, sys_rst_in = 1, por_rst_in = 1, standby_wakeup_in = 0, sel_in = 0, write_in = 0;
	logic detector_lock_in = 0, core_deep_sleep_request_in = 0, internal_osc_8mhz_in = 0, wakeup_event_in = 0;
	logic backup_write_in = 1, error_out, backup_write_out, regulator_voltage_low_out, detector_enable_out;
	logic standby_flag_clear_out, wakeup_flag_clear_out, regulator_low_power_out, standby_flag_out, wakeup_flag_out;
	logic [3:0] addr_in = 0, byte_en_in = 0;
	logic [1:0] size_in = 0;
	logic [2:0] detector_threshold_out;
	logic [1:0] clr;
	pwc_word_t wdata_in = 0, rdata_out, seed = 75, d, e;
	pwc_mode_e mode_out;
	int num_errors = 0, total_checks = 0;
	pwc_ctrl dut (.*);
	always #25 sys_clk_in = ~sys_clk_in;
	function automatic pwc_word_t nx();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// lock freezes bits 7:4, strobe and reserved bits never stick
	function automatic pwc_word_t ex(pwc_word_t o, pwc_word_t v, logic lk);
		return lk ? (v & 32'h0000C103) | (o & 32'h000000F0) : v & 32'h0000C1F3;
	endfunction
	task automatic chk(string n, pwc_word_t g, pwc_word_t x);
		total_checks++;
		if (g !== x)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one access; strobes are caught in the request cycle
	task automatic acc(logic w, logic hw, pwc_word_t v);
		@(posedge sys_clk_in);
		sel_in <= 1;
		write_in <= w;
		size_in <= hw ? 2'h1 : 2'h2;
		byte_en_in <= hw ? 4'h3 : 4'hF;
		wdata_in <= v;
		#1 clr = {standby_flag_clear_out, wakeup_flag_clear_out};
		@(posedge sys_clk_in);
		sel_in <= 0;
		#1;
	endtask
	initial
	begin
		repeat (3000) @(posedge sys_clk_in);
		num_errors++;
		give_verdict();
	end
	initial
	begin
		repeat (8) @(posedge sys_clk_in);
		sys_rst_in <= 0;
		por_rst_in <= 0;
		acc(0, 0, 0);
		chk("rst", rdata_out, 32'h00004000);
		e = 32'h00004000;
		repeat (30)
		begin
			d = nx();
			detector_lock_in = d[20];
			e = ex(e, d, d[20]);
			// reserved bits kept at reset value; strobe bits 3:2 are also written to check the clear pulses
			acc(1, d[16], d & 32'h0000C1FF);
			chk("clr", clr, d[3:2]);
			chk("out", {regulator_voltage_low_out, backup_write_out, detector_threshold_out, detector_enable_out},
				{e[15], e[8], e[7:4]});
			acc(0, d[17], 0);
			chk("rd", rdata_out, e);
		end
		detector_lock_in = 0;
		// illegal size is refused and flagged one cycle later
		@(posedge sys_clk_in);
		sel_in <= 1;
		write_in <= 1;
		size_in <= 2'h0;
		byte_en_in <= 4'hF;
		wdata_in <= 32'h0000C1F3;
		@(posedge sys_clk_in);
		sel_in <= 0;
		#1 chk("err", error_out, 1);
		acc(0, 0, 0);
		chk("noeff", rdata_out, e);
		acc(1, 0, 32'h00004001);
		core_deep_sleep_request_in = 1;
		repeat (2) @(posedge sys_clk_in);
		#1 chk("deep", {mode_out, regulator_low_power_out}, {PWC_DEEP, 1'b1});
		internal_osc_8mhz_in = 1;
		#1 chk("osc", regulator_low_power_out, 0);
		core_deep_sleep_request_in = 0;
		acc(1, 0, 32'h00004002);
		core_deep_sleep_request_in = 1;
		repeat (3) @(posedge sys_clk_in);
		#1 chk("stby", {mode_out, standby_flag_out}, {PWC_STANDBY, 1'b1});
		core_deep_sleep_request_in = 0;
		wakeup_event_in = 1;
		acc(1, 0, 32'h00004000);
		wakeup_event_in = 0;
		chk("flg", {standby_flag_out, wakeup_flag_out}, 2'h3);
		acc(1, 0, 32'h0000400C);
		chk("fclr", {standby_flag_out, wakeup_flag_out}, 2'h0);
		acc(1, 0, 32'h0000C1F3);
		standby_wakeup_in = 1;
		@(posedge sys_clk_in);
		#1 standby_wakeup_in = 0;
		acc(0, 0, 0);
		chk("wake", rdata_out, 32'h00004000);
		give_verdict();
	end
endmodule // tb_pwc_ctrl
